// >>> adcc_cal_ctrl.sv
// Purpose: calibration sequencing, constant array access and time-stamp capture
// Assumes: pins synchronous to sys_clk except the time-stamp trigger
// Notes: serial shifting is done outside; this block sees decoded register strobes
//
// What this block does
// - with time-stamp enabled, output LSB of all four buses carries sampled trigger
// - trigger may be asynchronous; synchronised inside before capture
// - calibration starts after request low then high for minimum cycles
// - in extended mode pin and bit are ORed; both must fall before rearming
// - running output high for whole calibration, low otherwise
// - after power-up wait short or long delay, then calibrate automatically
// - delay-select change while idle starts a calibration
// - request high at power-on skips power-on calibration
// - sequence select resets to one: trim plus linearity; zero: linearity only
// - constants sit in an array reached through one values register
// - save: set access bit, read 240 times, first is dummy
// - restore: set access bit, write 239 values plus two zero dummies
// - both channels down pauses calibration; either up resumes it
// - identical sequence whatever started the calibration
// - outputs low during calibration; valid 60 cycles after running falls
`timescale 1ns/1ps
`default_nettype none
module adcc_cal_ctrl
    import adcc_pkg::*;
#(
    parameter int CAL_LOW_MIN = 80,
    parameter int CAL_HIGH_MIN = 80,
    parameter int CAL_TRIM_CYC = 1024,
    parameter int CAL_LIN_CYC = 4096,
    parameter int CAL_DLY_SHORT = 4096,
    parameter int CAL_DLY_LONG = 65536
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic calibration_request,
    input wire logic calibration_delay_select,
    input wire logic extended_control_mode,
    input wire logic power_down_ch_a,
    input wire logic power_down_ch_b,
    input wire logic output_clock_reset_in,
    input wire adcc_samples_s samples_in,
    output adcc_samples_s samples_out,
    output logic calibration_running,
    output logic powered_down,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata
);
    adcc_state_e state_r;
    logic [15:0] main_cfg_r;
    logic [15:0] cal_adj_r;
    logic [31:0] lo_cnt_r;
    logic [31:0] hi_cnt_r;
    logic armed_r;
    logic [31:0] wait_cnt_r;
    logic [31:0] cal_cnt_r;
    logic dly_prev_r;
    logic trig_sync;
    logic [15:0] cal_array [0:ADCC_ARRAY_DEPTH-1];
    logic [7:0] ptr_r;
    logic dummy_pend_r;
    logic ssc_prev_r;
    logic req_any;
    logic cmd_start;
    logic dly_change;
    logic paused;
    logic calibration_array_access;
    logic timestamp_enable;
    logic por_done;
    logic cal_go;
    // ****************************************
    // decoding helpers
    // ****************************************
    function automatic logic is_calibrating(input adcc_state_e st);
        return (st == ADCC_ST_TRIM) || (st == ADCC_ST_LIN);
    endfunction : is_calibrating
    function automatic logic [ADCC_DATA_W-1:0] stamp(input logic [ADCC_DATA_W-1:0] d, input logic en,
                                                     input logic t);
        return en ? {d[ADCC_DATA_W-1:1], t} : d;
    endfunction : stamp
    assign calibration_array_access = cal_adj_r[ADCC_BIT_ARRAY_ACCESS];
    assign timestamp_enable = main_cfg_r[ADCC_BIT_TIMESTAMP_EN];
    assign req_any = calibration_request | (extended_control_mode & main_cfg_r[ADCC_BIT_CAL_REQ]);
    assign paused = power_down_ch_a & power_down_ch_b;
    assign powered_down = paused & is_calibrating(state_r);
    assign calibration_running = is_calibrating(state_r);
    assign dly_change = calibration_delay_select != dly_prev_r;
    assign cmd_start = armed_r & req_any & (hi_cnt_r == 32'(CAL_HIGH_MIN - 1));
    assign por_done = wait_cnt_r == (calibration_delay_select ? 32'(CAL_DLY_LONG - 1) : 32'(CAL_DLY_SHORT - 1));
    assign cal_go = (state_r == ADCC_ST_POR_WAIT) ? (por_done && !cmd_start && !dly_change)
        : ((state_r == ADCC_ST_IDLE && (cmd_start || dly_change)) || (state_r == ADCC_ST_FLUSH && cmd_start));
    // ****************************************
    // request filter
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lo_cnt_r <= '0;
            hi_cnt_r <= '0;
            armed_r <= 1'b0;
        end else if (req_any) begin
            lo_cnt_r <= '0;
            hi_cnt_r <= cmd_start ? '0 : (armed_r ? hi_cnt_r + 32'd1 : '0);
            if (cmd_start) begin
                armed_r <= 1'b0;
            end
        end else begin
            hi_cnt_r <= '0;
            if (lo_cnt_r < 32'(CAL_LOW_MIN)) begin
                lo_cnt_r <= lo_cnt_r + 32'd1;
            end
            if (lo_cnt_r >= 32'(CAL_LOW_MIN - 1)) begin
                armed_r <= 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dly_prev_r <= 1'b0;
        end else begin
            dly_prev_r <= calibration_delay_select;
        end
    end
    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= ADCC_ST_BOOT;
            wait_cnt_r <= '0;
            cal_cnt_r <= '0;
        end else begin
            case (state_r)
                ADCC_ST_BOOT: begin
                    wait_cnt_r <= '0;
                    state_r <= req_any ? ADCC_ST_IDLE : ADCC_ST_POR_WAIT;
                end
                ADCC_ST_POR_WAIT: begin
                    if (cal_go) begin
                        cal_cnt_r <= '0;
                        state_r <= cal_adj_r[ADCC_BIT_SEQ_SELECT] ? ADCC_ST_TRIM : ADCC_ST_LIN;
                    end else if (cmd_start || dly_change) begin
                        wait_cnt_r <= '0;
                    end else begin
                        wait_cnt_r <= wait_cnt_r + 32'd1;
                    end
                end
                ADCC_ST_IDLE, ADCC_ST_FLUSH: begin
                    if (cal_go) begin
                        cal_cnt_r <= '0;
                        state_r <= cal_adj_r[ADCC_BIT_SEQ_SELECT] ? ADCC_ST_TRIM : ADCC_ST_LIN;
                    end else if (state_r == ADCC_ST_FLUSH) begin
                        if (cal_cnt_r == 32'(ADCC_FLUSH_CYC - 1)) begin
                            state_r <= ADCC_ST_IDLE;
                        end else begin
                            cal_cnt_r <= cal_cnt_r + 32'd1;
                        end
                    end
                end
                ADCC_ST_TRIM: begin
                    if (!paused) begin
                        if (cal_cnt_r == 32'(CAL_TRIM_CYC - 1)) begin
                            cal_cnt_r <= '0;
                            state_r <= ADCC_ST_LIN;
                        end else begin
                            cal_cnt_r <= cal_cnt_r + 32'd1;
                        end
                    end
                end
                ADCC_ST_LIN: begin
                    if (!paused) begin
                        if (cal_cnt_r == 32'(CAL_LIN_CYC - 1)) begin
                            cal_cnt_r <= '0;
                            state_r <= ADCC_ST_FLUSH;
                        end else begin
                            cal_cnt_r <= cal_cnt_r + 32'd1;
                        end
                    end
                end
                default: begin
                    state_r <= ADCC_ST_IDLE;
                end
            endcase
        end
    end
    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            main_cfg_r <= ADCC_RST_MAIN_CFG;
            cal_adj_r <= ADCC_RST_CAL_ADJ;
        end else if (reg_wr) begin
            if (reg_addr == ADCC_ADDR_MAIN_CFG) begin
                main_cfg_r <= reg_wdata;
            end
            if (reg_addr == ADCC_ADDR_CAL_ADJ) begin
                cal_adj_r <= reg_wdata;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ssc_prev_r <= 1'b0;
            ptr_r <= '0;
            dummy_pend_r <= 1'b0;
        end else begin
            ssc_prev_r <= calibration_array_access;
            if (calibration_array_access && !ssc_prev_r) begin
                ptr_r <= '0;
                dummy_pend_r <= 1'b1;
            end else if (calibration_array_access && reg_addr == ADCC_ADDR_CAL_VALUES && (reg_rd || reg_wr)) begin
                if (reg_rd && dummy_pend_r) begin
                    dummy_pend_r <= 1'b0;
                end else if (ptr_r < ADCC_ARRAY_LAST) begin
                    ptr_r <= ptr_r + 8'h01;
                end
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (calibration_array_access && ssc_prev_r && reg_wr && reg_addr == ADCC_ADDR_CAL_VALUES && ptr_r < ADCC_ARRAY_LAST) begin
            cal_array[ptr_r] <= reg_wdata;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                ADCC_ADDR_MAIN_CFG: reg_rdata <= main_cfg_r;
                ADCC_ADDR_CAL_ADJ: reg_rdata <= cal_adj_r;
                ADCC_ADDR_CAL_VALUES: begin
                    reg_rdata <= (calibration_array_access && !dummy_pend_r && ptr_r < ADCC_ARRAY_LAST) ? cal_array[ptr_r] : '0;
                end
                default: reg_rdata <= '0;
            endcase
        end
    end
    // ****************************************
    // output path and time stamp
    // ****************************************
    adcc_sync2 u_trig_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(output_clock_reset_in),
        .sync_out(trig_sync)
    );
    always_ff @(posedge sys_clk) begin
        if (reset || cal_go || is_calibrating(state_r)
            || (state_r == ADCC_ST_FLUSH && cal_cnt_r != 32'(ADCC_FLUSH_CYC - 1))) begin
            samples_out <= '0;
        end else begin
            samples_out.i_bus <= stamp(samples_in.i_bus, timestamp_enable, trig_sync);
            samples_out.i_delayed_bus <= stamp(samples_in.i_delayed_bus, timestamp_enable, trig_sync);
            samples_out.q_bus <= stamp(samples_in.q_bus, timestamp_enable, trig_sync);
            samples_out.q_delayed_bus <= stamp(samples_in.q_delayed_bus, timestamp_enable, trig_sync);
            samples_out.over_range_i <= samples_in.over_range_i;
            samples_out.over_range_q <= samples_in.over_range_q;
        end
    end
    // ****************************************
    // checks
    // ****************************************
    sequence s_run_fall;
        $fell(calibration_running);
    endsequence
    chk_flush_quiet: assert property (@(posedge sys_clk) disable iff (reset)
        s_run_fall |-> ##1 (samples_out == '0) [*8]) else $error("outputs not low after calibration");
    chk_run_out: assert property (@(posedge sys_clk) disable iff (reset)
        calibration_running |=> (samples_out == '0)) else $error("outputs active during calibration");
    chk_start_run: assert property (@(posedge sys_clk) disable iff (reset)
        (cmd_start && state_r == ADCC_ST_IDLE) |=> calibration_running) else $error("request did not start");
    chk_rearm_low: assert property (@(posedge sys_clk) disable iff (reset)
        cmd_start |=> !armed_r) else $error("request rearmed without low time");
    chk_pause_hold: assert property (@(posedge sys_clk) disable iff (reset)
        (calibration_running && paused) |=> ($stable(cal_cnt_r) && calibration_running)) else $error("pause lost");
    chk_boot_skip: assert property (@(posedge sys_clk) disable iff (reset)
        (state_r == ADCC_ST_BOOT && req_any) |=> state_r == ADCC_ST_IDLE) else $error("power-on cal not skipped");
    chk_ptr_clear: assert property (@(posedge sys_clk) disable iff (reset)
        (calibration_array_access && !ssc_prev_r) |=> (ptr_r == 8'h00 && dummy_pend_r)) else $error("pointer not cleared");
    chk_stamp_lsb: assert property (@(posedge sys_clk) disable iff (reset)
        (timestamp_enable && state_r == ADCC_ST_IDLE && $past(state_r) == ADCC_ST_IDLE && !cal_go)
        |=> samples_out.i_bus[0] == $past(trig_sync) && samples_out.q_delayed_bus[0] == $past(trig_sync))
        else $error("time stamp bit wrong");
    chk_seq_sel: assert property (@(posedge sys_clk) disable iff (reset)
        (state_r == ADCC_ST_IDLE && cmd_start) |=> (state_r == (cal_adj_r[ADCC_BIT_SEQ_SELECT] ? ADCC_ST_TRIM : ADCC_ST_LIN)
        || $past(cal_adj_r[ADCC_BIT_SEQ_SELECT]) != cal_adj_r[ADCC_BIT_SEQ_SELECT])) else $error("sequence select ignored");
endmodule : adcc_cal_ctrl
`default_nettype wire

// >>> adcc_host_model.sv
// Purpose: host controller model for the calibration pin and register port
// Assumes: drives just after rising edges of sys_clk
// Notes: register accesses wait while a calibration runs
`timescale 1ns/1ps
`default_nettype none
module adcc_host_model (
    input wire logic sys_clk,
    input wire logic calibration_running,
    input wire logic [15:0] reg_rdata,
    output logic calibration_request,
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    // ****************************************
    // pin and register tasks
    // ****************************************
    initial begin
        calibration_request = 1'b0;
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic set_req(input logic v);
        @(posedge sys_clk);
        calibration_request <= v;
    endtask : set_req
    task automatic cal_pulse(input int lo, input int hi);
        @(posedge sys_clk);
        calibration_request <= 1'b0;
        repeat (lo) @(posedge sys_clk);
        calibration_request <= 1'b1;
        repeat (hi) @(posedge sys_clk);
        calibration_request <= 1'b0;
    endtask : cal_pulse
    task automatic wait_idle();
        while (calibration_running !== 1'b0) @(posedge sys_clk);
    endtask : wait_idle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        wait_idle();
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        wait_idle();
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : adcc_host_model
`default_nettype wire

// >>> adcc_pkg.sv
// Purpose: shared constants and types of the converter calibration control block
// Assumes: one 125 MHz sampling-derived clock, synchronous active-high reset
// Notes: register offsets are register indices on the serial register port
package adcc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADCC_ADDR_MAIN_CFG = 4'h0;
    localparam logic [3:0] ADCC_ADDR_CAL_ADJ = 4'h4;
    localparam logic [3:0] ADCC_ADDR_CAL_VALUES = 4'h5;
    localparam int ADCC_BIT_CAL_REQ = 15;
    localparam int ADCC_BIT_TIMESTAMP_EN = 3;
    localparam int ADCC_BIT_SEQ_SELECT = 14;
    localparam int ADCC_BIT_ARRAY_ACCESS = 7;
    localparam logic [15:0] ADCC_RST_MAIN_CFG = 16'h0000;
    localparam logic [15:0] ADCC_RST_CAL_ADJ = 16'h4000;
    // ****************************************
    // timing and sizes
    // ****************************************
    localparam int ADCC_FLUSH_CYC = 60;
    localparam int ADCC_ARRAY_DEPTH = 239;
    localparam logic [7:0] ADCC_ARRAY_LAST = 8'hEF;
    localparam int ADCC_DATA_W = 12;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ADCC_ST_BOOT = 3'b000,
        ADCC_ST_POR_WAIT = 3'b001,
        ADCC_ST_IDLE = 3'b010,
        ADCC_ST_TRIM = 3'b011,
        ADCC_ST_LIN = 3'b100,
        ADCC_ST_FLUSH = 3'b101
    } adcc_state_e;
    typedef struct packed {
        logic [ADCC_DATA_W-1:0] i_bus;
        logic [ADCC_DATA_W-1:0] i_delayed_bus;
        logic [ADCC_DATA_W-1:0] q_bus;
        logic [ADCC_DATA_W-1:0] q_delayed_bus;
        logic over_range_i;
        logic over_range_q;
    } adcc_samples_s;
endpackage : adcc_pkg

// >>> adcc_sync2.sv
// Purpose: two-flop synchroniser for a level from another timing domain
// Assumes: single destination clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module adcc_sync2 (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;
    // ****************************************
    // two stages
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : adcc_sync2
`default_nettype wire

// >>> tb.sv
// Purpose: self-checking bench for the calibration control block
// Assumes: shortened counts set at the instance
// Notes: host model drives calibration pin and register port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adcc_pkg::*;
    localparam int TRIM = 8;
    localparam int LIN = 16;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic calibration_delay_select = 1'b0;
    logic extended_control_mode = 1'b0;
    logic power_down_ch_a = 1'b0;
    logic power_down_ch_b = 1'b0;
    logic output_clock_reset_in = 1'b0;
    adcc_samples_s samples_in = '0;
    adcc_samples_s samples_out;
    logic calibration_request, calibration_running, powered_down, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [15:0] vals [239];
    logic rnd_on = 1'b1;
    int num_errors = 0;
    int comparisons = 0;
    // ****************************************
    // instances and helpers
    // ****************************************
    adcc_cal_ctrl #(.CAL_LOW_MIN(4), .CAL_HIGH_MIN(4), .CAL_TRIM_CYC(TRIM), .CAL_LIN_CYC(LIN),
        .CAL_DLY_SHORT(16), .CAL_DLY_LONG(32)) adcc_cal_ctrl_i (.sys_clk, .reset,
        .calibration_request, .calibration_delay_select, .extended_control_mode,
        .power_down_ch_a, .power_down_ch_b, .output_clock_reset_in, .samples_in, .samples_out,
        .calibration_running, .powered_down, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    adcc_host_model adcc_host_model_i (.sys_clk, .calibration_running, .reg_rdata,
        .calibration_request, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
    always #4 sys_clk = ~sys_clk;
    function automatic adcc_samples_s rnd_s();
        logic [63:0] r;
        r = {$urandom, $urandom};
        return r[49:0];
    endfunction : rnd_s
    function automatic adcc_samples_s exp_out(input adcc_samples_s s, input logic ts, input logic t);
        exp_out = s;
        if (ts) begin
            exp_out.i_bus[0] = t;
            exp_out.i_delayed_bus[0] = t;
            exp_out.q_bus[0] = t;
            exp_out.q_delayed_bus[0] = t;
        end
    endfunction : exp_out
    always @(posedge sys_clk) begin
        if (rnd_on) begin
            samples_in <= rnd_s();
        end
    end
    task automatic check(input logic [49:0] seen, input logic [49:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
        adcc_host_model_i.rd(a, d);
        check(50'(d), 50'(exp), what);
    endtask : rd_chk
    task automatic cal_len(input int exp, input string what);
        int n;
        int t;
        n = 0;
        t = 0;
        #1;
        while (calibration_running !== 1'b1 && t < 200) begin
            @(posedge sys_clk);
            #1;
            t++;
        end
        while (calibration_running === 1'b1 && n < 500) begin
            check(samples_out, '0, "outputs during calibration");
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(50'(n), 50'(exp), what);
    endtask : cal_len
    task automatic hold_chk(input logic ts, input logic t);
        #1 rnd_on = 1'b0;
        @(posedge sys_clk);
        samples_in <= rnd_s();
        output_clock_reset_in <= t;
        repeat (5) @(posedge sys_clk);
        #1 check(samples_out, exp_out(samples_in, ts, t), "output word");
        rnd_on = 1'b1;
    endtask : hold_chk
    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask : end_test
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (30000) @(posedge sys_clk);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict();
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        void'($urandom(32'h9dfe));
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        cal_len(TRIM + LIN, "power-on calibration");
        repeat (ADCC_FLUSH_CYC - 1) begin
            @(posedge sys_clk);
            #1 check(samples_out, '0, "flush");
        end
        hold_chk(1'b0, 1'b0);
        end_test("power-on");
        rd_chk(ADCC_ADDR_MAIN_CFG, 16'h0000, "main config reset");
        rd_chk(ADCC_ADDR_CAL_ADJ, 16'h4000, "sequence select default");
        adcc_host_model_i.wr(4'h9, 16'hFFFF);
        rd_chk(4'h9, 16'h0000, "unmapped read");
        adcc_host_model_i.wr(ADCC_ADDR_MAIN_CFG, 16'h0008);
        hold_chk(1'b1, 1'b1);
        hold_chk(1'b1, 1'b0);
        adcc_host_model_i.wr(ADCC_ADDR_MAIN_CFG, 16'h0000);
        hold_chk(1'b0, 1'b1);
        end_test("registers and time stamp");
        adcc_host_model_i.cal_pulse(4, 3);
        cal_len(0, "short pulse");
        adcc_host_model_i.cal_pulse(4, 4);
        cal_len(TRIM + LIN, "pin calibration");
        adcc_host_model_i.wr(ADCC_ADDR_CAL_ADJ, 16'h0000);
        adcc_host_model_i.cal_pulse(4, 4);
        cal_len(LIN, "linearity only");
        adcc_host_model_i.wr(ADCC_ADDR_CAL_ADJ, 16'h4000);
        @(posedge sys_clk);
        extended_control_mode <= 1'b1;
        adcc_host_model_i.wr(ADCC_ADDR_MAIN_CFG, 16'h8000);
        cal_len(TRIM + LIN, "register bit calibration");
        adcc_host_model_i.cal_pulse(4, 4);
        cal_len(0, "pin while bit high");
        adcc_host_model_i.wr(ADCC_ADDR_MAIN_CFG, 16'h0000);
        adcc_host_model_i.cal_pulse(4, 4);
        cal_len(TRIM + LIN, "pin after both low");
        repeat (ADCC_FLUSH_CYC) @(posedge sys_clk);
        @(posedge sys_clk);
        calibration_delay_select <= 1'b1;
        cal_len(TRIM + LIN, "delay select change");
        end_test("calibration starts");
        adcc_host_model_i.cal_pulse(4, 4);
        fork
            cal_len(TRIM + LIN + 10, "paused calibration");
            begin
                repeat (4) @(posedge sys_clk);
                power_down_ch_a <= 1'b1;
                power_down_ch_b <= 1'b1;
                repeat (5) @(posedge sys_clk);
                #1 check(50'(powered_down), 50'(1), "powered down");
                repeat (5) @(posedge sys_clk);
                power_down_ch_a <= 1'b0;
            end
        join
        power_down_ch_b <= 1'b0;
        adcc_host_model_i.cal_pulse(4, 4);
        cal_len(TRIM + LIN, "recalibration after power-up");
        end_test("power-down");
        adcc_host_model_i.wr(ADCC_ADDR_CAL_ADJ, 16'h4080);
        foreach (vals[i]) begin
            vals[i] = 16'($urandom);
            adcc_host_model_i.wr(ADCC_ADDR_CAL_VALUES, vals[i]);
        end
        repeat (2) adcc_host_model_i.wr(ADCC_ADDR_CAL_VALUES, 16'h0000);
        adcc_host_model_i.wr(ADCC_ADDR_CAL_ADJ, 16'h4000);
        adcc_host_model_i.wr(ADCC_ADDR_CAL_ADJ, 16'h4080);
        rd_chk(ADCC_ADDR_CAL_VALUES, 16'h0000, "dummy read");
        foreach (vals[i]) rd_chk(ADCC_ADDR_CAL_VALUES, vals[i], "array entry");
        adcc_host_model_i.wr(ADCC_ADDR_CAL_ADJ, 16'h4000);
        rd_chk(ADCC_ADDR_CAL_VALUES, 16'h0000, "values without access");
        end_test("array save and restore");
        @(posedge sys_clk);
        reset <= 1'b1;
        calibration_delay_select <= 1'b0;
        adcc_host_model_i.set_req(1'b1);
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        cal_len(0, "request high at power-on");
        adcc_host_model_i.cal_pulse(4, 4);
        cal_len(TRIM + LIN, "request after power-on");
        end_test("request at power-on");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
